// [codec_regs_consts.svh]
// register indices, field positions, defaults and timing counts
`ifndef CODEC_REGS_CONSTS_SVH
`define CODEC_REGS_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_SOFT_RESET 6'h00
`define IDX_BIAS 6'h04
`define IDX_MIDRAIL 6'h05
`define IDX_MIC_DETECT 6'h06
`define IDX_MIC_VOLTAGE 6'h07
`define IDX_DMIC 6'h0a
`define IDX_INPUT_PWR 6'h0c
`define IDX_HP_PWR 6'h0e
`define IDX_LINE_PWR 6'h0f
`define IDX_CONV_PWR 6'h12
`define IDX_CLK_RATE 6'h14
`define IDX_CLK_AUX 6'h16

// field positions (lowest bit of each field)
`define POS_MAIN_BIAS 0
`define POS_MID_BUF 6
`define POS_MID_DIV 1
`define POS_MID_SRC 0
`define POS_MIC_CUR_THR 4
`define POS_MIC_SHORT_THR 2
`define POS_MIC_DET_EN 1
`define POS_MIC_SUP_EN 0
`define POS_MIC_VOLT 0
`define POS_DMIC_RATE 0
`define POS_LEFT 1
`define POS_RIGHT 0
`define POS_CONV_LEFT 3
`define POS_CONV_RIGHT 2
`define POS_TO_DIV16 14
`define POS_TO_X4 13
`define POS_SYS_HALVE 0
`define POS_TO_ENABLE 0

// reset values of non-zero fields
`define RST_DMIC_RATE 1'h1
`define RST_DEVICE_ID 16'h5a3c

// timing count in system clock ticks and top mic supply level
`define TIMEOUT_BASE_TICKS 16'h0100
`define MIC_LEVEL_MAX 3'h4

`endif

// [codec_regs_pkg.sv]
// types shared by the codec control register bank
package codec_regs_pkg;

    typedef enum logic [1:0] {
        MIDRAIL_OFF,
        MIDRAIL_NORMAL_50K,
        MIDRAIL_STANDBY_250K,
        MIDRAIL_FAST_5K
    } midrail_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic main_bias_enable;
        logic midrail_buffer_enable;
        logic [1:0] midrail_divider_select;
        logic midrail_source_enable;
        logic [2:0] mic_current_threshold;
        logic [1:0] mic_short_threshold;
        logic mic_detect_enable;
        logic mic_supply_enable;
        logic [2:0] mic_supply_voltage;
        logic digital_mic_rate_select;
        logic left_input_amp_enable;
        logic right_input_amp_enable;
        logic left_headphone_enable;
        logic right_headphone_enable;
        logic left_line_out_enable;
        logic right_line_out_enable;
        logic left_converter_enable;
        logic right_converter_enable;
        logic left_mic_filter_enable;
        logic right_mic_filter_enable;
        logic timeout_clock_div_sixteen;
        logic timeout_clock_times_four;
        logic system_clock_halve;
        logic zero_cross_timeout_enable;
    } ctrl_t;

    typedef struct packed {
        ctrl_t ctrl;
        midrail_mode_t midrail_mode;
        logic [2:0] mic_supply_level;
        logic dmic_rate_reserved;
        apb_rsp_t rsp;
        logic sys_phase;
        logic system_clock_tick;
        logic [15:0] timeout_count;
        logic timeout_clock_tick;
    } state_t;

endpackage

// [codec_regs.sv]
// codec power, bias and clock control registers behind an apb slave
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "codec_regs_consts.svh"

module codec_regs #(
    parameter logic [15:0] DEVICE_ID = `RST_DEVICE_ID, // arbitrary value
    parameter logic [15:0] TIMEOUT_BASE = `TIMEOUT_BASE_TICKS
) (
    input wire logic clk,
    input wire logic rst,
    input wire codec_regs_pkg::apb_req_t apb_req,
    output codec_regs_pkg::apb_rsp_t apb_rsp,
    output codec_regs_pkg::ctrl_t ctrl,
    output codec_regs_pkg::midrail_mode_t midrail_mode,
    output logic [2:0] mic_supply_level,
    output logic dmic_rate_reserved,
    output logic system_clock_tick,
    output logic timeout_clock_tick
);

    // power-on and soft-reset values of every control field
    function automatic codec_regs_pkg::ctrl_t ctrl_defaults();
        codec_regs_pkg::ctrl_t c;
        c = '0;
        c.digital_mic_rate_select = `RST_DMIC_RATE;
        return c;
    endfunction

    // true for indices that hold a register
    function automatic logic is_mapped(input logic [5:0] idx);
        logic m;
        m = 1'b0;
        case (idx)
            `IDX_SOFT_RESET, `IDX_BIAS, `IDX_MIDRAIL, `IDX_MIC_DETECT,
            `IDX_MIC_VOLTAGE, `IDX_DMIC, `IDX_INPUT_PWR, `IDX_HP_PWR,
            `IDX_LINE_PWR, `IDX_CONV_PWR, `IDX_CLK_RATE, `IDX_CLK_AUX: begin
                m = 1'b1;
            end
            default: begin
                m = 1'b0;
            end
        endcase
        return m;
    endfunction

    // read mux; bits without a field stay zero
    function automatic logic [15:0] read_reg(
        input codec_regs_pkg::ctrl_t c,
        input logic [5:0] idx
    );
        logic [15:0] r;
        r = 16'h0000;
        case (idx)
            // identity code, never a stored value
            `IDX_SOFT_RESET: begin
                r = DEVICE_ID;
            end

            // main bias generator
            `IDX_BIAS: begin
                r[`POS_MAIN_BIAS] = c.main_bias_enable;
            end

            // mid-rail buffer, divider and source
            `IDX_MIDRAIL: begin
                r[`POS_MID_BUF] = c.midrail_buffer_enable;
                r[`POS_MID_DIV +: 2] = c.midrail_divider_select;
                r[`POS_MID_SRC] = c.midrail_source_enable;
            end

            // mic supply thresholds and enables
            `IDX_MIC_DETECT: begin
                r[`POS_MIC_CUR_THR +: 3] = c.mic_current_threshold;
                r[`POS_MIC_SHORT_THR +: 2] = c.mic_short_threshold;
                r[`POS_MIC_DET_EN] = c.mic_detect_enable;
                r[`POS_MIC_SUP_EN] = c.mic_supply_enable;
            end

            // raw voltage code, not the saturated level
            `IDX_MIC_VOLTAGE: begin
                r[`POS_MIC_VOLT +: 3] = c.mic_supply_voltage;
            end

            // digital mic oversampling bit
            `IDX_DMIC: begin
                r[`POS_DMIC_RATE] = c.digital_mic_rate_select;
            end

            // input amplifier enables
            `IDX_INPUT_PWR: begin
                r[`POS_LEFT] = c.left_input_amp_enable;
                r[`POS_RIGHT] = c.right_input_amp_enable;
            end

            // headphone stage enables
            `IDX_HP_PWR: begin
                r[`POS_LEFT] = c.left_headphone_enable;
                r[`POS_RIGHT] = c.right_headphone_enable;
            end

            // line output enables
            `IDX_LINE_PWR: begin
                r[`POS_LEFT] = c.left_line_out_enable;
                r[`POS_RIGHT] = c.right_line_out_enable;
            end

            // converter and mic filter enables
            `IDX_CONV_PWR: begin
                r[`POS_CONV_LEFT] = c.left_converter_enable;
                r[`POS_CONV_RIGHT] = c.right_converter_enable;
                r[`POS_LEFT] = c.left_mic_filter_enable;
                r[`POS_RIGHT] = c.right_mic_filter_enable;
            end

            // timeout scaling and system clock halving
            `IDX_CLK_RATE: begin
                r[`POS_TO_DIV16] = c.timeout_clock_div_sixteen;
                r[`POS_TO_X4] = c.timeout_clock_times_four;
                r[`POS_SYS_HALVE] = c.system_clock_halve;
            end

            // timeout clock enable
            `IDX_CLK_AUX: begin
                r[`POS_TO_ENABLE] = c.zero_cross_timeout_enable;
            end

            // holes in the map read zero
            default: begin
                r = 16'h0000;
            end
        endcase
        return r;
    endfunction

    // write decode; only defined fields take data
    function automatic codec_regs_pkg::ctrl_t write_reg(
        input codec_regs_pkg::ctrl_t c,
        input logic [5:0] idx,
        input logic [15:0] w
    );
        codec_regs_pkg::ctrl_t n;
        n = c;
        case (idx)
            // data ignored, every field back to default
            `IDX_SOFT_RESET: begin
                n = ctrl_defaults();
            end

            // main bias generator
            `IDX_BIAS: begin
                n.main_bias_enable = w[`POS_MAIN_BIAS];
            end

            // mid-rail buffer, divider and source
            `IDX_MIDRAIL: begin
                n.midrail_buffer_enable = w[`POS_MID_BUF];
                n.midrail_divider_select = w[`POS_MID_DIV +: 2];
                n.midrail_source_enable = w[`POS_MID_SRC];
            end

            // mic supply thresholds and enables
            `IDX_MIC_DETECT: begin
                n.mic_current_threshold = w[`POS_MIC_CUR_THR +: 3];
                n.mic_short_threshold = w[`POS_MIC_SHORT_THR +: 2];
                n.mic_detect_enable = w[`POS_MIC_DET_EN];
                n.mic_supply_enable = w[`POS_MIC_SUP_EN];
            end

            // all eight voltage codes are stored as written
            `IDX_MIC_VOLTAGE: begin
                n.mic_supply_voltage = w[`POS_MIC_VOLT +: 3];
            end

            // software must clear this before mic use
            `IDX_DMIC: begin
                n.digital_mic_rate_select = w[`POS_DMIC_RATE];
            end

            // input amplifier enables
            `IDX_INPUT_PWR: begin
                n.left_input_amp_enable = w[`POS_LEFT];
                n.right_input_amp_enable = w[`POS_RIGHT];
            end

            // headphone stage enables
            `IDX_HP_PWR: begin
                n.left_headphone_enable = w[`POS_LEFT];
                n.right_headphone_enable = w[`POS_RIGHT];
            end

            // line output enables
            `IDX_LINE_PWR: begin
                n.left_line_out_enable = w[`POS_LEFT];
                n.right_line_out_enable = w[`POS_RIGHT];
            end

            // converter and mic filter enables
            `IDX_CONV_PWR: begin
                n.left_converter_enable = w[`POS_CONV_LEFT];
                n.right_converter_enable = w[`POS_CONV_RIGHT];
                n.left_mic_filter_enable = w[`POS_LEFT];
                n.right_mic_filter_enable = w[`POS_RIGHT];
            end

            // timeout scaling and system clock halving
            `IDX_CLK_RATE: begin
                n.timeout_clock_div_sixteen = w[`POS_TO_DIV16];
                n.timeout_clock_times_four = w[`POS_TO_X4];
                n.system_clock_halve = w[`POS_SYS_HALVE];
            end

            // timeout clock enable
            `IDX_CLK_AUX: begin
                n.zero_cross_timeout_enable = w[`POS_TO_ENABLE];
            end

            // writes to holes change nothing
            default: begin
                n = c;
            end
        endcase
        return n;
    endfunction

    // timeout period in system ticks after divide and multiply
    function automatic logic [15:0] timeout_period(input codec_regs_pkg::ctrl_t c);
        logic [15:0] p;
        p = TIMEOUT_BASE;
        // a slower clock means a longer period
        if (c.timeout_clock_div_sixteen) begin
            p = {p[11:0], 4'h0};
        end
        // a faster clock means a shorter period
        if (c.timeout_clock_times_four) begin
            p = {2'h0, p[15:2]};
        end
        // never let the period collapse to zero
        if (p == 16'h0000) begin
            p = 16'h0001;
        end
        return p;
    endfunction

    // five voltage levels; codes above the top one saturate
    function automatic logic [2:0] mic_level(input logic [2:0] code);
        logic [2:0] l;
        l = code;
        if (code > `MIC_LEVEL_MAX) begin
            l = `MIC_LEVEL_MAX;
        end
        return l;
    endfunction

    // full state at power-on
    function automatic codec_regs_pkg::state_t state_defaults();
        codec_regs_pkg::state_t s;
        s = '0;
        s.ctrl = ctrl_defaults();
        s.midrail_mode = codec_regs_pkg::MIDRAIL_OFF;
        return s;
    endfunction

    // constant image loaded by the asynchronous reset
    localparam codec_regs_pkg::state_t STATE_RESET = state_defaults();

    // state register, its next value and decode nets
    codec_regs_pkg::state_t state_q;
    codec_regs_pkg::state_t state_d;
    logic [5:0] req_idx;
    logic req_aligned;
    logic req_mapped;
    logic setup_phase;
    logic access_done;
    logic [15:0] next_count;

    // address decode and apb phase detection
    assign req_idx = apb_req.paddr[7:2];
    assign req_aligned = (apb_req.paddr[1:0] == 2'h0);
    assign req_mapped = req_aligned && is_mapped(req_idx);
    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign access_done = apb_req.psel && apb_req.penable && state_q.rsp.pready;
    assign next_count = state_q.timeout_count + 16'h0001;

    // next state: bus answer, register update, clock ticks
    always_comb begin
        state_d = state_q;
        state_d.rsp.pready = 1'b0;

        // answer every setup in the following access cycle
        if (setup_phase) begin
            state_d.rsp.pready = 1'b1;
            state_d.rsp.pslverr = !req_mapped;
            state_d.rsp.prdata = 32'h0000_0000;
            if (req_mapped && !apb_req.pwrite) begin
                state_d.rsp.prdata = {16'h0000, read_reg(state_q.ctrl, req_idx)};
            end
        end

        // a write lands only at the completing access edge
        if (access_done && apb_req.pwrite && req_mapped) begin
            state_d.ctrl = write_reg(state_q.ctrl, req_idx, apb_req.pwdata[15:0]);
        end

        // system clock: every cycle, or every second one when halved
        if (state_q.ctrl.system_clock_halve) begin
            state_d.sys_phase = !state_q.sys_phase;
        end else begin
            state_d.sys_phase = 1'b0;
        end
        state_d.system_clock_tick = !state_q.ctrl.system_clock_halve || state_q.sys_phase;

        // timeout clock counts system ticks only while enabled
        state_d.timeout_clock_tick = 1'b0;
        if (!state_q.ctrl.zero_cross_timeout_enable) begin
            state_d.timeout_count = 16'h0000;
        end else if (state_q.system_clock_tick) begin
            if (next_count >= timeout_period(state_q.ctrl)) begin
                state_d.timeout_count = 16'h0000;
                state_d.timeout_clock_tick = 1'b1;
            end else begin
                state_d.timeout_count = next_count;
            end
        end

        // decoded views of the new settings
        state_d.midrail_mode =
            codec_regs_pkg::midrail_mode_t'(state_d.ctrl.midrail_divider_select);
        state_d.mic_supply_level = mic_level(state_d.ctrl.mic_supply_voltage);
        state_d.dmic_rate_reserved = state_d.ctrl.digital_mic_rate_select &&
            (state_d.ctrl.left_mic_filter_enable || state_d.ctrl.right_mic_filter_enable);
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from the state register
    assign apb_rsp = state_q.rsp;
    assign ctrl = state_q.ctrl;
    assign midrail_mode = state_q.midrail_mode;
    assign mic_supply_level = state_q.mic_supply_level;
    assign dmic_rate_reserved = state_q.dmic_rate_reserved;
    assign system_clock_tick = state_q.system_clock_tick;
    assign timeout_clock_tick = state_q.timeout_clock_tick;

endmodule

// [codec_regs_assertions.sv]
// assertion checker for the codec control register bank
`timescale 1ns/100ps
module codec_regs_assertions #(
    parameter logic [15:0] DEVICE_ID = 16'h0000, // arbitrary value
    parameter logic [15:0] TIMEOUT_BASE = 16'h0008
) (
    input wire logic clk,
    input wire logic rst,
    input wire codec_regs_pkg::apb_req_t apb_req,
    input wire codec_regs_pkg::apb_rsp_t apb_rsp,
    input wire codec_regs_pkg::ctrl_t ctrl,
    input wire codec_regs_pkg::midrail_mode_t midrail_mode,
    input wire logic [2:0] mic_supply_level,
    input wire logic dmic_rate_reserved,
    input wire logic system_clock_tick,
    input wire logic timeout_clock_tick
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic acc;
    logic wr;
    codec_regs_pkg::ctrl_t dflt;
    // completed transfers and the default control word
    assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign wr = acc && apb_req.pwrite;
    always_comb begin
        dflt = '0;
        dflt.digital_mic_rate_select = 1'b1;
    end
    property p_id;
        acc && !apb_req.pwrite && apb_req.paddr == 8'h00
            |-> apb_rsp.prdata == {16'h0000, DEVICE_ID};
    endproperty
    a_id: assert property (p_id) else $error("identity read wrong");
    property p_upper;
        acc |-> apb_rsp.prdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_soft;
        wr && apb_req.paddr == 8'h00 |=> ctrl == dflt;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset missed");
    property p_bias;
        wr && apb_req.paddr == 8'h10 |=> ctrl.main_bias_enable == $past(apb_req.pwdata[0]);
    endproperty
    a_bias: assert property (p_bias) else $error("bias enable not stored");
    property p_divider;
        $stable(ctrl.midrail_divider_select)
            |-> midrail_mode == codec_regs_pkg::midrail_mode_t'(ctrl.midrail_divider_select);
    endproperty
    a_divider: assert property (p_divider) else $error("divider mode wrong");
    property p_level;
        $stable(ctrl.mic_supply_voltage) |-> mic_supply_level
            == (ctrl.mic_supply_voltage > 3'h4 ? 3'h4 : ctrl.mic_supply_voltage);
    endproperty
    a_level: assert property (p_level) else $error("supply level wrong");
    property p_halve;
        ctrl.system_clock_halve [*3] |-> system_clock_tick != $past(system_clock_tick);
    endproperty
    a_halve: assert property (p_halve) else $error("halved tick wrong");
    property p_idle;
        !ctrl.zero_cross_timeout_enable [*3] |-> !timeout_clock_tick;
    endproperty
    a_idle: assert property (p_idle) else $error("timeout tick while off");
endmodule
bind codec_regs codec_regs_assertions #(.DEVICE_ID(DEVICE_ID), .TIMEOUT_BASE(TIMEOUT_BASE))
    u_chk (.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .ctrl(ctrl),
    .midrail_mode(midrail_mode), .mic_supply_level(mic_supply_level),
    .dmic_rate_reserved(dmic_rate_reserved), .system_clock_tick(system_clock_tick),
    .timeout_clock_tick(timeout_clock_tick));

// [codec_regs_tb.sv]
// self-checking bench for the codec control register bank
`timescale 1ns/100ps
`include "codec_regs_consts.svh"
module codec_regs_tb;
    localparam logic [15:0] ID = 16'h7e21; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    codec_regs_pkg::apb_req_t req = '0;
    codec_regs_pkg::apb_rsp_t rsp;
    codec_regs_pkg::ctrl_t ctrl;
    codec_regs_pkg::ctrl_t dflt = '0;
    codec_regs_pkg::midrail_mode_t mode;
    logic [2:0] lvl;
    logic resv;
    logic stick;
    logic ttick;
    logic [15:0] shadow [64];
    logic [33:0] notes [$];
    logic [31:0] rate [4] = '{32'h2000, 32'h0, 32'h1, 32'h4000};
    logic [31:0] per [4] = '{32'h2, 32'h8, 32'h10, 32'h80};
    int failures = 0;
    int checks = 0;
    int seed = 32'h65f0;
    int i;
    int r;
    int s;
    int t;
    // 250 MHz clock
    always #2 clk = ~clk;
    codec_regs #(.DEVICE_ID(ID), .TIMEOUT_BASE(16'h0008)) uut (.clk(clk), .rst(rst),
        .apb_req(req), .apb_rsp(rsp), .ctrl(ctrl), .midrail_mode(mode),
        .mic_supply_level(lvl), .dmic_rate_reserved(resv), .system_clock_tick(stick),
        .timeout_clock_tick(ttick));
    // writable bits of each register index
    function automatic logic [15:0] mask(input logic [5:0] x);
        case (x)
            `IDX_BIAS, `IDX_DMIC, `IDX_CLK_AUX: mask = 16'h0001;
            `IDX_MIDRAIL: mask = 16'h0047;
            `IDX_MIC_DETECT: mask = 16'h007f;
            `IDX_MIC_VOLTAGE: mask = 16'h0007;
            `IDX_INPUT_PWR, `IDX_HP_PWR, `IDX_LINE_PWR: mask = 16'h0003;
            `IDX_CONV_PWR: mask = 16'h000f;
            `IDX_CLK_RATE: mask = 16'h6001;
            default: mask = 16'h0000;
        endcase
    endfunction
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic fail(input string m);
        failures++;
        $display("Error %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks++;
        if (g !== e) begin
            fail(m);
        end
    endtask
    // expected register contents after any reset
    task automatic reset_shadow();
        for (int k = 0; k < 64; k++)
            shadow[k] = 16'h0000;
        shadow[`IDX_DMIC] = 16'h0001;
    endtask
    // one apb transfer; the expected response is noted first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic [5:0] x;
        logic ok;
        logic [31:0] e;
        int k;
        x = a[7:2];
        ok = a[1:0] == 2'b00 && (x == 6'h00 || mask(x) != 16'h0000);
        e = x == 6'h00 ? {16'h0000, ID} : {16'h0000, shadow[x]};
        notes.push_back({!w, !ok, ok && !w ? e : 32'h0});
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        if (k == 20) begin
            fail("no ready");
            close_out();
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (w && ok && x == 6'h00)
            reset_shadow();
        else if (w && ok)
            shadow[x] = d[15:0] & mask(x);
    endtask
    task automatic readall();
        for (int k = 0; k < 64; k++)
            apb(1'b0, 8'(k * 4), 32'h0);
    endtask
    // cycles between two timeout ticks
    task automatic gap(output int g);
        for (int k = 0; k < 3000 && ttick !== 1'b1; k++)
            @(posedge clk);
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (ttick !== 1'b1 && g < 3000);
        if (g == 3000) begin
            fail("no timeout tick");
            close_out();
        end
    endtask
    // count both tick outputs over c cycles
    task automatic tally(input int c);
        s = 0;
        t = 0;
        repeat (c) begin
            @(posedge clk);
            s += stick;
            t += ttick;
        end
    endtask
    // compare each completed transfer with the oldest note
    always @(posedge clk) begin : mon
        logic [33:0] e;
        if (!rst && req.psel && req.penable && rsp.pready && notes.size() > 0) begin
            e = notes.pop_front();
            checks++;
            if (rsp.pslverr !== e[32] || (e[33] && rsp.prdata !== e[31:0])) begin
                fail("transfer response");
            end
        end
    end
    // main sequence
    initial begin
        dflt.digital_mic_rate_select = 1'b1;
        reset_shadow();
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        readall();
        apb(1'b0, 8'h16, 32'h0);
        $display("defaults done");
        for (r = 0; r < 4; r++) begin
            for (i = 1; i < 64; i++)
                apb(1'b1, 8'(i * 4), r == 3 ? 32'hffffffff : $random(seed));
            apb(1'b1, 8'h11, 32'h0);
            readall();
        end
        chk(32'(ctrl), 32'h3fffffff, "all set");
        $display("readback done");
        apb(1'b1, 8'h00, $random(seed));
        @(posedge clk);
        chk(32'(ctrl), 32'(dflt), "soft reset");
        readall();
        $display("soft reset done");
        for (i = 0; i < 8; i++) begin
            apb(1'b1, {`IDX_MIC_VOLTAGE, 2'b00}, 32'(i));
            apb(1'b1, {`IDX_MIDRAIL, 2'b00}, 32'(i * 2));
            tally(3);
            chk(32'(lvl), i > 4 ? 32'h4 : 32'(i), "level");
            chk(32'(mode), 32'(i % 4), "divider");
        end
        apb(1'b1, {`IDX_CONV_PWR, 2'b00}, 32'h2);
        tally(3);
        chk(32'(resv), 32'h1, "rate flag set");
        apb(1'b1, {`IDX_DMIC, 2'b00}, 32'h0);
        tally(3);
        chk(32'(resv), 32'h0, "rate flag clear");
        $display("codes done");
        for (i = 0; i < 4; i++) begin
            apb(1'b1, {`IDX_CLK_RATE, 2'b00}, rate[i]);
            if (i == 0)
                apb(1'b1, {`IDX_CLK_AUX, 2'b00}, 32'h1);
            gap(t);
            gap(t);
            chk(32'(t), per[i], "timeout period");
            tally(20);
            chk(32'(s), rate[i][0] ? 32'h0a : 32'h14, "system ticks");
        end
        apb(1'b1, {`IDX_CLK_AUX, 2'b00}, 32'h0);
        tally(3);
        tally(300);
        chk(32'(t), 32'h0, "timeout idle");
        $display("clocks done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reset_shadow();
        readall();
        $display("reset done");
        close_out();
    end
endmodule
